// file: sts_pkg.sv
// constants for the selected transmitter shutdown handler
// assumes a 32-bit apb register bus with word-aligned registers
package sts_pkg;

	// ************************************************************
	// register indices, byte address is four times the index
	// ************************************************************
	localparam logic [15:0] STS_IDX_CTRL = 16'h0001;
	localparam logic [15:0] STS_IDX_BUS_A_SEL = 16'h0012;
	localparam logic [15:0] STS_IDX_BUS_B_SEL = 16'h0013;
	localparam logic [15:0] STS_IDX_BIT_WORD = 16'h0014;
	localparam int STS_ADDR_W = 8;
	localparam int STS_IDX_W = 6;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [15:0] STS_SEL_RESET = 16'h0000;
	localparam logic [11:0] STS_BIT_LOW_RESET = 12'h000;
	localparam logic [3:0] STS_CTRL_RESET = 4'h0;

	// ************************************************************
	// control register fields
	// ************************************************************
	localparam int STS_CTRL_OPT4_BIT = 0;
	localparam int STS_CTRL_SCOPE_BIT = 1;
	localparam int STS_CTRL_INH_A_BIT = 2;
	localparam int STS_CTRL_INH_B_BIT = 3;
	localparam int STS_CTRL_W = 4;

	// ************************************************************
	// built-in-test word status bits and mode codes
	// ************************************************************
	localparam int STS_BIT_TXSD_A = 15;
	localparam int STS_BIT_RXSD_A = 14;
	localparam int STS_BIT_TXSD_B = 13;
	localparam int STS_BIT_RXSD_B = 12;
	localparam int STS_BIT_HOST_W = 12;
	localparam logic [4:0] STS_MC_SEL_SHUTDOWN = 5'h14;
	localparam logic [4:0] STS_MC_SEL_OVERRIDE = 5'h15;

endpackage

// file: sts_shutdown_handler.sv
// selected transmitter shutdown and override handler with apb registers
// assumes command strobes come from the remote terminal decoder, one pulse per command
//
// Overview of operation
// - act on mode codes 20 and 21 only when mode data equals select value
// - only the inactive bus is affected, using that bus's select register
// - shutdown disables inactive tx and rx, or tx only when scope select set
// - after shutdown set matching built-in-test word status bits 15 to 12
// - override re-enables inactive tx, and rx too when scope select clear
// - after override clear matching built-in-test word status bits 15 to 12
// - with option bit clear, shutdown and override happen automatically on match
// - with option bit set, only status returned; host uses transmit inhibit bits
module sts_shutdown_handler
	import sts_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [STS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_valid,
	input wire logic [4:0] mode_code,
	input wire logic [15:0] mode_data,
	input wire logic active_bus,
	output logic tx_enable_a,
	output logic tx_enable_b,
	output logic rx_enable_a,
	output logic rx_enable_b,
	output logic [15:0] bit_word
);

	// ************************************************************
	// register state
	// ************************************************************
	logic [15:0] sel_a_q;
	logic [15:0] sel_b_q;
	logic [STS_CTRL_W-1:0] ctrl_q;
	logic [STS_BIT_HOST_W-1:0] bit_low_q;
	logic [1:0] tx_off_q;
	logic [1:0] rx_off_q;
	logic [31:0] prdata_q;

	// ************************************************************
	// apb decode
	// ************************************************************
	wire [STS_IDX_W-1:0] idx = paddr[STS_ADDR_W-1:2];
	wire aligned = (paddr[1:0] == 2'b00);
	wire hit_ctrl = aligned && (idx == STS_IDX_CTRL[STS_IDX_W-1:0]);
	wire hit_sel_a = aligned && (idx == STS_IDX_BUS_A_SEL[STS_IDX_W-1:0]);
	wire hit_sel_b = aligned && (idx == STS_IDX_BUS_B_SEL[STS_IDX_W-1:0]);
	wire hit_bit = aligned && (idx == STS_IDX_BIT_WORD[STS_IDX_W-1:0]);
	wire mapped = hit_ctrl || hit_sel_a || hit_sel_b || hit_bit;
	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable;
	wire wr_ok = clk_en && access_ph && pwrite && mapped;
	wire rd_setup = clk_en && setup_ph && !pwrite;

	assign pready = access_ph;
	assign pslverr = access_ph && !mapped;
	assign prdata = prdata_q;

	wire opt4 = ctrl_q[STS_CTRL_OPT4_BIT];
	wire scope = ctrl_q[STS_CTRL_SCOPE_BIT];
	wire inh_a = ctrl_q[STS_CTRL_INH_A_BIT];
	wire inh_b = ctrl_q[STS_CTRL_INH_B_BIT];

	wire [15:0] status_bits = {12'h000, tx_off_q[0], rx_off_q[0], tx_off_q[1], rx_off_q[1]};
	wire [15:0] bit_word_w = (status_bits << STS_BIT_RXSD_B) | {4'h0, bit_low_q};

	wire [31:0] rd_mux = hit_ctrl ? {28'h0000_000, ctrl_q} :
		hit_sel_a ? {16'h0000, sel_a_q} :
		hit_sel_b ? {16'h0000, sel_b_q} :
		hit_bit ? {16'h0000, bit_word_w} : 32'h0000_0000;

	// ************************************************************
	// command qualification
	// ************************************************************
	// the inactive bus is the one the command did not arrive on
	wire inactive = !active_bus;
	wire [15:0] inactive_sel = inactive ? sel_b_q : sel_a_q;
	wire data_match = (mode_data == inactive_sel);
	wire is_sd = (mode_code == STS_MC_SEL_SHUTDOWN);
	wire is_ov = (mode_code == STS_MC_SEL_OVERRIDE);
	wire cmd_fire = clk_en && cmd_valid;
	// host-handled option suppresses automatic action
	wire auto_ok = cmd_fire && data_match && !opt4;
	wire do_sd = auto_ok && is_sd;
	wire do_ov = auto_ok && is_ov;
	wire sd_a = do_sd && !inactive;
	wire sd_b = do_sd && inactive;
	wire ov_a = do_ov && !inactive;
	wire ov_b = do_ov && inactive;
	wire [1:0] sd_bus = {sd_b, sd_a};
	wire [1:0] ov_bus = {ov_b, ov_a};

	// ************************************************************
	// apb registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= STS_CTRL_RESET;
			sel_a_q <= STS_SEL_RESET;
			sel_b_q <= STS_SEL_RESET;
			bit_low_q <= STS_BIT_LOW_RESET;
		end else if (wr_ok) begin
			if (hit_ctrl) begin
				ctrl_q <= pwdata[STS_CTRL_W-1:0];
			end
			if (hit_sel_a) begin
				sel_a_q <= pwdata[15:0];
			end
			if (hit_sel_b) begin
				sel_b_q <= pwdata[15:0];
			end
			if (hit_bit) begin
				bit_low_q <= pwdata[STS_BIT_HOST_W-1:0];
			end
		end
	end

	// read data is captured in the setup phase so it is ready with no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_q <= rd_mux;
		end
	end

	// ************************************************************
	// per-bus shutdown state
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_bus
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tx_off_q[g] <= 1'b0;
					rx_off_q[g] <= 1'b0;
				end else if (sd_bus[g]) begin
					tx_off_q[g] <= 1'b1;
					if (!scope) begin
						rx_off_q[g] <= 1'b1;
					end
				end else if (ov_bus[g]) begin
					tx_off_q[g] <= 1'b0;
					if (!scope) begin
						rx_off_q[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ************************************************************
	// outputs
	// ************************************************************
	// host transmit inhibit works in every option setting
	assign tx_enable_a = !tx_off_q[0] && !inh_a;
	assign tx_enable_b = !tx_off_q[1] && !inh_b;
	assign rx_enable_a = !rx_off_q[0];
	assign rx_enable_b = !rx_off_q[1];
	assign bit_word = bit_word_w;

	// ************************************************************
	// assertions
	// ************************************************************
	sequence s_shut_a;
		sd_a ##1 1'b1;
	endsequence

	sequence s_over_b;
		ov_b ##1 1'b1;
	endsequence

	sequence s_shut_b;
		sd_b ##1 1'b1;
	endsequence

	sequence s_over_a;
		ov_a ##1 1'b1;
	endsequence

	property p_shut_tx_a;
		@(posedge pclk) disable iff (!presetn)
		s_shut_a |-> !tx_enable_a && bit_word[STS_BIT_TXSD_A];
	endproperty
	a_shut_tx_a: assert property (p_shut_tx_a) else $error("tx a not shut");

	property p_shut_rx_scope;
		@(posedge pclk) disable iff (!presetn)
		sd_b && !scope |=> !rx_enable_b && bit_word[STS_BIT_RXSD_B] && bit_word[STS_BIT_TXSD_B];
	endproperty
	a_shut_rx_scope: assert property (p_shut_rx_scope) else $error("rx b not shut");

	property p_scope_keeps_rx;
		@(posedge pclk) disable iff (!presetn)
		do_sd && scope |=> $stable(rx_off_q);
	endproperty
	a_scope_keeps_rx: assert property (p_scope_keeps_rx) else $error("rx changed");

	property p_active_untouched;
		@(posedge pclk) disable iff (!presetn)
		cmd_fire && !active_bus |=> $stable(tx_off_q[0]) && $stable(rx_off_q[0]);
	endproperty
	a_active_untouched: assert property (p_active_untouched) else $error("active bus hit");

	property p_over_b;
		@(posedge pclk) disable iff (!presetn)
		s_over_b |-> !tx_off_q[1] && !bit_word[STS_BIT_TXSD_B] && (scope || rx_enable_b);
	endproperty
	a_over_b: assert property (p_over_b) else $error("override b failed");

	property p_over_clear_a;
		@(posedge pclk) disable iff (!presetn)
		ov_a && !scope |=> !bit_word[STS_BIT_TXSD_A] && !bit_word[STS_BIT_RXSD_A];
	endproperty
	a_over_clear_a: assert property (p_over_clear_a) else $error("status a kept");

	property p_mismatch;
		@(posedge pclk) disable iff (!presetn)
		cmd_fire && !data_match |=> $stable(tx_off_q) && $stable(rx_off_q);
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch acted");

	property p_host_option;
		@(posedge pclk) disable iff (!presetn)
		cmd_fire && opt4 |=> $stable(bit_word[15:12]);
	endproperty
	a_host_option: assert property (p_host_option) else $error("auto action in host mode");

	property p_other_code;
		@(posedge pclk) disable iff (!presetn)
		cmd_fire && !is_sd && !is_ov |=> $stable(tx_off_q) && $stable(rx_off_q);
	endproperty
	a_other_code: assert property (p_other_code) else $error("other code acted");

	property p_auto;
		@(posedge pclk) disable iff (!presetn)
		cmd_fire && is_sd && !opt4 && data_match && active_bus |=> tx_off_q[0];
	endproperty
	a_auto: assert property (p_auto) else $error("auto shutdown missed");

	// mirror checks for the other bus and the remaining command steps
	property p_shut_tx_b;
		@(posedge pclk) disable iff (!presetn)
		s_shut_b |-> !tx_enable_b && bit_word[STS_BIT_TXSD_B];
	endproperty
	a_shut_tx_b: assert property (p_shut_tx_b) else $error("tx b not shut");

	property p_shut_rx_a;
		@(posedge pclk) disable iff (!presetn)
		sd_a && !scope |=> !rx_enable_a && bit_word[STS_BIT_RXSD_A] && bit_word[STS_BIT_TXSD_A];
	endproperty
	a_shut_rx_a: assert property (p_shut_rx_a) else $error("rx a not shut");

	property p_shut_scope_b;
		@(posedge pclk) disable iff (!presetn)
		sd_b && scope |=> bit_word[STS_BIT_TXSD_B] && $stable(bit_word[STS_BIT_RXSD_B]);
	endproperty
	a_shut_scope_b: assert property (p_shut_scope_b) else $error("scope status b wrong");

	property p_over_a;
		@(posedge pclk) disable iff (!presetn)
		s_over_a |-> !tx_off_q[0] && !bit_word[STS_BIT_TXSD_A] && (scope || rx_enable_a);
	endproperty
	a_over_a: assert property (p_over_a) else $error("override a failed");

	property p_over_scope_keeps_rx;
		@(posedge pclk) disable iff (!presetn)
		do_ov && scope |=> $stable(rx_off_q);
	endproperty
	a_over_scope_keeps_rx: assert property (p_over_scope_keeps_rx) else $error("rx moved");

	property p_over_clear_b;
		@(posedge pclk) disable iff (!presetn)
		ov_b && !scope |=> !bit_word[STS_BIT_TXSD_B] && !bit_word[STS_BIT_RXSD_B];
	endproperty
	a_over_clear_b: assert property (p_over_clear_b) else $error("status b kept");

	property p_active_b_untouched;
		@(posedge pclk) disable iff (!presetn)
		cmd_fire && active_bus |=> $stable(tx_off_q[1]) && $stable(rx_off_q[1]);
	endproperty
	a_active_b_untouched: assert property (p_active_b_untouched) else $error("bus b hit");

	property p_host_keeps_enables;
		@(posedge pclk) disable iff (!presetn)
		cmd_fire && opt4 |=> $stable(tx_off_q) && $stable(rx_off_q);
	endproperty
	a_host_keeps_enables: assert property (p_host_keeps_enables) else $error("host mode acted");

	property p_auto_over;
		@(posedge pclk) disable iff (!presetn)
		cmd_fire && is_ov && !opt4 && data_match && !active_bus |=> !tx_off_q[1];
	endproperty
	a_auto_over: assert property (p_auto_over) else $error("auto override missed");

endmodule

// file: sts_bc_model.sv
// bus controller model issuing selected shutdown and override mode commands
// assumes the bench calls send from one process, between commands only
module sts_bc_model (
	input wire logic pclk,
	output logic cmd_valid,
	output logic [4:0] mode_code,
	output logic [15:0] mode_data,
	output logic active_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_valid = 1'b0;
		mode_code = 5'h00;
		mode_data = 16'h0000;
		active_bus = 1'b0;
	end
	// one-cycle pulse; fields are scrambled outside the pulse
	task automatic send(input logic [4:0] c, input logic [15:0] d, input logic b);
		@(posedge pclk);
		cmd_valid <= 1'b1;
		mode_code <= c;
		mode_data <= d;
		active_bus <= b;
		@(posedge pclk);
		cmd_valid <= 1'b0;
		mode_code <= ~c;
		mode_data <= ~d;
		active_bus <= ~b;
	endtask
endmodule

// file: sts_shutdown_handler_bench.sv
// self-checking bench for the selected shutdown handler
// assumes nothing of apb wait states; the watchdog bounds every wait
module sts_shutdown_handler_bench;
	import sts_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, er, cmd_valid, active_bus, tx_enable_a, tx_enable_b;
	logic rx_enable_a, rx_enable_b;
	logic [4:0] mode_code;
	logic [15:0] mode_data, bit_word, sel_a, sel_b, d;
	logic [3:0] ctrl = 4'h0, sd = 4'h0;
	logic [11:0] low = 12'h000;
	logic [31:0] r;
	logic [4:0] codes [8] = '{5'h14, 5'h15, 5'h14, 5'h15, 5'h14, 5'h15, 5'h04, 5'h16};
	int seed = 64, err_total = 0, cmp_count = 0;
	always #50 pclk = ~pclk;
	sts_shutdown_handler dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .mode_code(mode_code),
		.mode_data(mode_data), .active_bus(active_bus), .tx_enable_a(tx_enable_a),
		.tx_enable_b(tx_enable_b), .rx_enable_a(rx_enable_a), .rx_enable_b(rx_enable_b),
		.bit_word(bit_word));
	sts_bc_model bc_u (.pclk(pclk), .cmd_valid(cmd_valid), .mode_code(mode_code),
		.mode_data(mode_data), .active_bus(active_bus));
	// ****
	// checks and bus cycles
	// ****
	task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t read %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_out();
		logic [19:0] e;
		e = {~sd[3] & ~ctrl[2], ~sd[1] & ~ctrl[3], ~sd[2], ~sd[0], sd, low};
		cmp_count++;
		if ({tx_enable_a, tx_enable_b, rx_enable_a, rx_enable_b, bit_word} !== e) begin
			err_total++;
			$display("[ERR] %0t enables or status word differ, expected %h", $time, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input logic [4:0] c, input logic [15:0] dd, input logic b,
		input logic en);
		logic [3:0] mk;
		@(posedge pclk);
		clk_en <= en;
		bc_u.send(c, dd, b);
		clk_en <= 1'b1;
		mk = b ? (ctrl[1] ? 4'b1000 : 4'b1100) : (ctrl[1] ? 4'b0010 : 4'b0011);
		if (en && !ctrl[0] && dd === (b ? sel_a : sel_b) && (c == 5'h14 || c == 5'h15)) begin
			sd = (c == 5'h14) ? (sd | mk) : (sd & ~mk);
		end
		@(negedge pclk);
		chk_out();
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#3_000_000;
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test();
	end
	// ****
	// main sequence
	// ****
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (codes[i]) begin
			apb(1'b0, 8'h04 + (i % 4 > 0 ? 8'h40 + 8'(i % 4) * 8'h04 : 8'h00), 32'h0000_0000);
			chk_rd(rd, 32'h0000_0000);
		end
		chk_out();
		r = $random(seed);
		sel_a = r[15:0];
		sel_b = r[15:0] ^ 16'h5a5a;
		apb(1'b1, 8'h48, {16'h0000, sel_a});
		apb(1'b1, 8'h4c, {16'h0000, sel_b});
		clk_en <= 1'b0;
		apb(1'b1, 8'h48, 32'h0000_1234);
		clk_en <= 1'b1;
		apb(1'b1, 8'h49, 32'h0000_ffff);
		chk_rd({31'h0, er}, 32'h0000_0001);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk_rd({rd[30:0], er}, 32'h0000_0001);
		apb(1'b0, 8'h48, 32'h0000_0000);
		chk_rd(rd, {16'h0000, sel_a});
		apb(1'b0, 8'h4c, 32'h0000_0000);
		chk_rd(rd, {16'h0000, sel_b});
		apb(1'b1, 8'h50, 32'hffff_ffff);
		low = 12'hfff;
		for (int i = 0; i < 96; i++) begin
			r = $random(seed);
			ctrl = {r[3:1], r[0] & r[16]};
			apb(1'b1, 8'h04, {28'h000_0000, ctrl});
			case (r[5:4])
				2'd0: d = sel_a;
				2'd1: d = sel_b;
				2'd2: d = sel_a ^ (16'h0001 << r[11:8]);
				default: d = r[31:16];
			endcase
			cmd(codes[r[14:12]], d, r[15], r[17] | r[18]);
			if (i % 8 == 7) begin
				apb(1'b0, 8'h50, 32'h0000_0000);
				chk_rd(rd, {16'h0000, sd, low});
			end
		end
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		sd = 4'h0;
		ctrl = 4'h0;
		low = 12'h000;
		sel_a = 16'h0000;
		sel_b = 16'h0000;
		@(negedge pclk);
		chk_out();
		apb(1'b0, 8'h4c, 32'h0000_0000);
		chk_rd(rd, 32'h0000_0000);
		cmd(5'h14, 16'h0000, 1'b1, 1'b1);
		cmd(5'h15, 16'h0000, 1'b1, 1'b1);
		finish_test();
	end
endmodule
